/* hw/rsttr_pkg.sv */
// constants and types for the return stack and table read block
package rsttr_pkg;
    localparam int PC_W = 13;
    localparam int STK_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int SECT_W = 3;
    localparam int MEM_WORDS = 8192;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [2:0] SECTOR_ZERO = 3'h0;
    localparam logic [4:0] LAST_PAGE_HIGH = 5'h1F;
    localparam logic [2:0] PTR_RESET = 3'h0;
    localparam logic [3:0] CNT_FULL = 4'h8;
    localparam logic [3:0] CNT_EMPTY = 4'h0;
    localparam logic [7:0] TABLE_RESULT_HIGH_BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // table instruction flavours
    typedef enum logic [1:0] {
        RSTTR_TF_NORMAL = 2'b00,
        RSTTR_TF_LAST_PAGE = 2'b01,
        RSTTR_TF_EXT = 2'b10,
        RSTTR_TF_EXT_LAST_PAGE = 2'b11
    } rsttr_tflavour_t;
    // table read sequencer
    typedef enum logic [1:0] {
        RSTTR_ST_IDLE = 2'b00,
        RSTTR_ST_FETCH = 2'b01,
        RSTTR_ST_WRITE = 2'b10
    } rsttr_state_t;
endpackage

/* hw/rsttr_core.sv */
// return address stack, program counter and table read path
// Behaviour
// R1: eight entry hidden stack holds program counters
// R2: push pc on call or interrupt acknowledge
// R3: return pops newest entry into pc
// R4: reset leaves the stack empty
// R5: full stack latches interrupt, withholds acknowledge
// R6: withheld interrupt acknowledged after a return
// R7: call still executes when stack full
// R8: overflow overwrites the oldest entry
// R9: alu status flags left to sequencer
// R10: alu operation set lives in sequencer
// R11: program memory 8192 words of 16 bits
// R12: fetch starts at address zero after reset
// R13: table address is high and low pointer
// R14: low byte to memory, high to register
// R15: plain reads sector zero, extended any sector
// R16: table instructions take two cycles
// R17: table high byte register software writable
// R18: pc is 13 bits, low byte exposed
// R19: circular stack with pointer and count
`timescale 1ns/1ps
module rsttr_core (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic step,
    input wire logic call_req,
    input wire logic [12:0] call_target,
    input wire logic subroutine_return,
    input wire logic interrupt_return,
    input wire logic int_req,
    input wire logic [12:0] int_vector,
    input wire logic int_clear,
    input wire logic pcl_we,
    input wire logic [7:0] pcl_wdata,
    input wire logic table_req,
    input wire logic [1:0] table_flavour,
    input wire logic [7:0] table_ptr_low,
    input wire logic [7:0] table_ptr_high,
    input wire logic [7:0] table_dest_addr,
    input wire logic [2:0] table_dest_sector,
    input wire logic table_result_high_byte_we,
    input wire logic [7:0] table_result_high_byte_wdata,
    input wire logic prog_we,
    input wire logic [12:0] prog_waddr,
    input wire logic [15:0] prog_wdata,
    output logic [12:0] pc,
    output logic [7:0] program_counter_low_byte,
    output logic [15:0] instr_word,
    output logic int_ack,
    output logic int_pending,
    output logic stack_full,
    output logic stack_overflow,
    output logic [7:0] table_result_high_byte,
    output logic dmem_we,
    output logic [7:0] dmem_addr,
    output logic [2:0] dmem_sector,
    output logic [7:0] dmem_wdata,
    output logic table_busy,
    output logic table_done
);
    // program memory, addressed by pc and by the table pointer
    logic [15:0] prog_mem [0:rsttr_pkg::MEM_WORDS-1]; // R11
    // return stack: never visible to software, only pc values stored
    logic [12:0] stack_mem [0:rsttr_pkg::STK_DEPTH-1]; // R1
    logic [2:0] sp_r, sp_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [12:0] pc_r, pc_nxt;
    logic pend_r, pend_nxt;
    logic ack_r, ack_nxt;
    logic ovf_r, ovf_nxt;
    logic full_r, full_nxt;
    logic push, pop, do_ack, is_ret;
    logic [12:0] push_val;
    logic [15:0] instr_r;
    logic [12:0] pop_val;

    rsttr_pkg::rsttr_state_t st_r, st_nxt;
    logic [12:0] taddr_r, taddr_nxt;
    logic [15:0] tword_r;
    logic [7:0] table_result_high_byte_r, table_result_high_byte_nxt;
    logic [7:0] daddr_r, daddr_nxt;
    logic [2:0] dsect_r, dsect_nxt;
    logic dwe_r, dwe_nxt;
    logic [7:0] dwdata_r, dwdata_nxt;
    logic done_r, done_nxt;
    logic busy_r, busy_nxt;

    // table address: last page flavours force the high part to the top page
    function automatic logic [12:0] table_addr(input logic [1:0] fl,
                                               input logic [7:0] hi,
                                               input logic [7:0] lo);
        logic [4:0] h;
        h = hi[4:0];
        if (fl[0]) begin
            h = rsttr_pkg::LAST_PAGE_HIGH;
        end
        return {h, lo}; // R13
    endfunction

    assign is_ret = subroutine_return | interrupt_return;
    assign pop_val = stack_mem[sp_r - 3'h1];

    // stack and pc next state; only one control event per step
    always_comb begin
        push = 1'b0;
        pop = 1'b0;
        do_ack = 1'b0;
        push_val = pc_r;
        sp_nxt = sp_r;
        cnt_nxt = cnt_r;
        pc_nxt = pc_r;
        ovf_nxt = ovf_r;
        ack_nxt = 1'b0;
        // request latched even when acknowledge is held back
        pend_nxt = (pend_r & ~int_clear) | int_req; // R5
        if (step) begin
            if (is_ret && cnt_r != rsttr_pkg::CNT_EMPTY) begin
                pop = 1'b1;
                pc_nxt = pop_val; // R3
                sp_nxt = sp_r - 3'h1;
                cnt_nxt = cnt_r - 4'h1;
            end else if (pend_r && cnt_r != rsttr_pkg::CNT_FULL) begin
                // freed level lets a deferred interrupt through
                do_ack = 1'b1; // R6
                push = 1'b1; // R2
                pc_nxt = int_vector;
                pend_nxt = int_req;
            end else if (call_req) begin
                push = 1'b1; // R2 R7
                pc_nxt = call_target;
            end else if (pcl_we) begin
                pc_nxt = {pc_r[12:8], pcl_wdata}; // R18
            end else if (!table_req || st_r != rsttr_pkg::RSTTR_ST_IDLE) begin
                pc_nxt = pc_r + 13'h0001;
            end
            if (push) begin
                // circular: when full, write over oldest and keep count at 8
                sp_nxt = sp_r + 3'h1; // R19 R8
                if (cnt_r == rsttr_pkg::CNT_FULL) begin
                    ovf_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 4'h1;
                end
            end
        end
        full_nxt = (cnt_nxt == rsttr_pkg::CNT_FULL);
        // acknowledge pulse follows the decision, so a withheld request never pulses
        ack_nxt = do_ack; // R5 R6
    end

    // stack state registers; reset empties the stack
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sp_r <= rsttr_pkg::PTR_RESET; // R4
            cnt_r <= rsttr_pkg::CNT_EMPTY; // R4
            pc_r <= rsttr_pkg::RESET_VECTOR; // R12
            pend_r <= 1'b0;
            ack_r <= 1'b0;
            ovf_r <= 1'b0;
            full_r <= 1'b0;
        end else begin
            sp_r <= sp_nxt;
            cnt_r <= cnt_nxt;
            pc_r <= pc_nxt;
            pend_r <= pend_nxt;
            ack_r <= ack_nxt;
            ovf_r <= ovf_nxt;
            full_r <= full_nxt;
        end
    end

    // stack storage and memory arrays carry no reset
    always_ff @(posedge core_clk) begin
        if (push) begin
            stack_mem[sp_r] <= push_val;
        end
        if (prog_we) begin
            prog_mem[prog_waddr] <= prog_wdata;
        end
        instr_r <= prog_mem[pc_nxt];
        tword_r <= prog_mem[taddr_nxt];
    end

    // table read: fetch cycle then write cycle, two cycles in all
    always_comb begin
        st_nxt = st_r;
        taddr_nxt = taddr_r;
        daddr_nxt = daddr_r;
        dsect_nxt = dsect_r;
        table_result_high_byte_nxt = table_result_high_byte_r;
        dwe_nxt = 1'b0;
        dwdata_nxt = dwdata_r;
        done_nxt = 1'b0;
        busy_nxt = 1'b0;
        if (table_result_high_byte_we) begin
            table_result_high_byte_nxt = table_result_high_byte_wdata; // R17
        end
        case (st_r)
            rsttr_pkg::RSTTR_ST_IDLE: begin
                if (table_req) begin
                    taddr_nxt = table_addr(table_flavour, table_ptr_high, table_ptr_low);
                    daddr_nxt = table_dest_addr;
                    // plain flavours are pinned to sector zero
                    dsect_nxt = table_flavour[1] ? table_dest_sector
                                                 : rsttr_pkg::SECTOR_ZERO; // R15
                    st_nxt = rsttr_pkg::RSTTR_ST_FETCH;
                    busy_nxt = 1'b1;
                end
            end
            rsttr_pkg::RSTTR_ST_FETCH: begin
                st_nxt = rsttr_pkg::RSTTR_ST_WRITE; // R16
                busy_nxt = 1'b1;
            end
            rsttr_pkg::RSTTR_ST_WRITE: begin
                dwe_nxt = 1'b1;
                dwdata_nxt = tword_r[7:0]; // R14
                table_result_high_byte_nxt = tword_r[15:8]; // R14
                done_nxt = 1'b1;
                st_nxt = rsttr_pkg::RSTTR_ST_IDLE;
            end
            default: begin
                st_nxt = rsttr_pkg::RSTTR_ST_IDLE;
            end
        endcase
    end

    // table read registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= rsttr_pkg::RSTTR_ST_IDLE;
            taddr_r <= rsttr_pkg::RESET_VECTOR;
            daddr_r <= rsttr_pkg::BYTE_ZERO;
            dsect_r <= rsttr_pkg::SECTOR_ZERO;
            table_result_high_byte_r <= rsttr_pkg::TABLE_RESULT_HIGH_BYTE_RESET;
            dwe_r <= 1'b0;
            dwdata_r <= rsttr_pkg::BYTE_ZERO;
            done_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            taddr_r <= taddr_nxt;
            daddr_r <= daddr_nxt;
            dsect_r <= dsect_nxt;
            table_result_high_byte_r <= table_result_high_byte_nxt;
            dwe_r <= dwe_nxt;
            dwdata_r <= dwdata_nxt;
            done_r <= done_nxt;
            busy_r <= busy_nxt;
        end
    end

    // alu flags and operations (R9, R10) belong to the sequencer datapath
    assign pc = pc_r;
    assign program_counter_low_byte = pc_r[7:0];
    assign instr_word = instr_r;
    assign int_ack = ack_r;
    assign int_pending = pend_r;
    assign stack_full = full_r;
    assign stack_overflow = ovf_r;
    assign table_result_high_byte = table_result_high_byte_r;
    assign dmem_we = dwe_r;
    assign dmem_addr = daddr_r;
    assign dmem_sector = dsect_r;
    assign dmem_wdata = dwdata_r;
    assign table_busy = busy_r;
    assign table_done = done_r;

    a_full_blocks_ack: assert property (@(posedge core_clk) disable iff (!reset_n)
        (cnt_r == rsttr_pkg::CNT_FULL && !(step && is_ret)) |=> !int_ack) // R5
        else $error("ack while stack full");
    a_ret_loads_pc: assert property (@(posedge core_clk) disable iff (!reset_n)
        (pop) |=> pc == $past(pop_val)) // R3
        else $error("return did not restore pc");
    a_call_pushes: assert property (@(posedge core_clk) disable iff (!reset_n)
        (push) |=> sp_r == $past(sp_r) + 3'h1) // R2
        else $error("push did not advance pointer");
    a_count_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
        cnt_r <= rsttr_pkg::CNT_FULL) // R19
        else $error("stack count out of range");
    a_overflow_keeps: assert property (@(posedge core_clk) disable iff (!reset_n)
        (push && cnt_r == 4'h8) |=> cnt_r == 4'h8 && stack_overflow) // R8
        else $error("overflow handling wrong");
    a_table_two_cyc: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r == rsttr_pkg::RSTTR_ST_IDLE && table_req)
        |=> busy_r ##1 busy_r ##1 (done_r && !busy_r)) // R16
        else $error("table read not two cycles");
    a_table_sector: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r == rsttr_pkg::RSTTR_ST_IDLE && table_req && !table_flavour[1])
        |=> ##2 dmem_sector == 3'h0) // R15
        else $error("plain table read left sector zero");
    a_table_result_high_byte_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        (table_result_high_byte_we && st_r != rsttr_pkg::RSTTR_ST_WRITE) |=> table_result_high_byte == $past(table_result_high_byte_wdata)) // R17
        else $error("table_result_high_byte write lost");
    a_table_low: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r == rsttr_pkg::RSTTR_ST_WRITE) |=> dmem_we && dmem_wdata == $past(tword_r[7:0])) // R14
        else $error("table low byte wrong");
    c_overflow: cover property (@(posedge core_clk) disable iff (!reset_n) push && cnt_r == 4'h8);
    c_deferred_ack: cover property (@(posedge core_clk) disable iff (!reset_n)
        pend_r && full_r ##[1:20] int_ack);
    c_table_ext: cover property (@(posedge core_clk) disable iff (!reset_n) dmem_we && dmem_sector != 3'h0);
    c_pcl_jump: cover property (@(posedge core_clk) disable iff (!reset_n)
        step && pcl_we && !is_ret && !call_req);
endmodule

/* bench/rsttr_dmem_model.sv */
// data memory stand-in that records what the table read unit writes
`timescale 1ns/1ps
module rsttr_dmem_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic dmem_we,
    input wire logic [7:0] dmem_addr,
    input wire logic [2:0] dmem_sector,
    input wire logic [7:0] dmem_wdata,
    output logic [15:0] last_wr,
    output logic [7:0] last_data,
    output logic [7:0] wr_count
);
    // take each one-cycle write pulse on the edge that sees it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_wr <= 16'h0000;
            last_data <= 8'h00;
            wr_count <= 8'h00;
        end else if (dmem_we) begin
            last_wr <= {5'h00, dmem_sector, dmem_addr};
            last_data <= dmem_wdata;
            wr_count <= wr_count + 8'h01; // a double pulse shows as an extra count
        end
    end
endmodule

/* bench/return_stack_and_table_read_tb_top.sv */
// self-checking bench for the return stack and table read block
`timescale 1ns/1ps
module return_stack_and_table_read_tb_top;
    logic core_clk = 1'b0, reset_n = 1'b0, step = 1'b0, call_req = 1'b0;
    logic subroutine_return = 1'b0, interrupt_return = 1'b0, int_req = 1'b0;
    logic int_clear = 1'b0, pcl_we = 1'b0, table_req = 1'b0, table_result_high_byte_we = 1'b0, prog_we = 1'b0;
    logic [12:0] call_target = 13'h0000, int_vector = 13'h0040, prog_waddr = 13'h0000;
    logic [7:0] pcl_wdata = 8'h00, table_ptr_low = 8'h34, table_ptr_high = 8'h02;
    logic [7:0] table_dest_addr = 8'h21, table_result_high_byte_wdata = 8'h00;
    logic [1:0] table_flavour = 2'b00;
    logic [2:0] table_dest_sector = 3'h5;
    logic [15:0] prog_wdata = 16'h0000, instr_word, last_wr, exp_w;
    logic [12:0] pc;
    logic [7:0] program_counter_low_byte, table_result_high_byte, dmem_addr, dmem_wdata;
    logic [7:0] last_data, wr_count;
    logic [2:0] dmem_sector;
    logic int_ack, int_pending, stack_full, stack_overflow, dmem_we, table_busy, table_done;
    int fail_count = 0, compares = 0, cycles = 0;

    always #4 core_clk = ~core_clk;

    rsttr_core u_rsttr_core (.core_clk(core_clk), .reset_n(reset_n), .step(step),
        .call_req(call_req), .call_target(call_target), .subroutine_return(subroutine_return),
        .interrupt_return(interrupt_return), .int_req(int_req), .int_vector(int_vector),
        .int_clear(int_clear), .pcl_we(pcl_we), .pcl_wdata(pcl_wdata), .table_req(table_req),
        .table_flavour(table_flavour), .table_ptr_low(table_ptr_low),
        .table_ptr_high(table_ptr_high), .table_dest_addr(table_dest_addr),
        .table_dest_sector(table_dest_sector), .table_result_high_byte_we(table_result_high_byte_we), .table_result_high_byte_wdata(table_result_high_byte_wdata),
        .prog_we(prog_we), .prog_waddr(prog_waddr), .prog_wdata(prog_wdata), .pc(pc),
        .program_counter_low_byte(program_counter_low_byte), .instr_word(instr_word),
        .int_ack(int_ack), .int_pending(int_pending), .stack_full(stack_full),
        .stack_overflow(stack_overflow), .table_result_high_byte(table_result_high_byte),
        .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_sector(dmem_sector),
        .dmem_wdata(dmem_wdata), .table_busy(table_busy), .table_done(table_done));

    rsttr_dmem_model u_rsttr_dmem_model (.core_clk(core_clk), .reset_n(reset_n),
        .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_sector(dmem_sector),
        .dmem_wdata(dmem_wdata), .last_wr(last_wr), .last_data(last_data), .wr_count(wr_count));

    task automatic finish_test();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // a hung handshake must still reach the verdict
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
    endtask

    // one instruction boundary; step stays up so back-to-back steps never toggle it
    task automatic do_step(input logic c, input logic [12:0] tgt, input logic r, input logic ir);
        step = 1'b1;
        call_req = c;
        call_target = tgt;
        subroutine_return = r;
        interrupt_return = ir;
        @(negedge core_clk);
    endtask

    // ends a run of steps; the next edge sees no instruction
    task automatic step_idle();
        step = 1'b0;
        call_req = 1'b0;
        subroutine_return = 1'b0;
        interrupt_return = 1'b0;
    endtask

    // write strobe held across consecutive loads, dropped by the caller
    task automatic prog_load(input logic [12:0] a, input logic [15:0] d);
        prog_we = 1'b1;
        prog_waddr = a;
        prog_wdata = d;
        @(negedge core_clk);
    endtask

    task automatic t_reset();
        chk(pc, 16'h0000);
        chk(stack_full, 16'h0000);
        prog_load(13'h0000, 16'hBEEF);
        prog_load(13'h0234, 16'hA55A);
        prog_load(13'h1F34, 16'h3CC3);
        prog_we = 1'b0;
        @(negedge core_clk);
        chk(instr_word, 16'hBEEF);
    endtask

    // nine calls overflow the eight levels; the oldest entry (0) is lost
    task automatic t_stack();
        for (int i = 1; i <= 9; i++) begin
            do_step(1'b1, 13'(i * 256), 1'b0, 1'b0);
            chk(pc, 16'(i * 256));
            if (i == 8) chk(stack_full, 16'h0001);
        end
        chk(stack_overflow, 16'h0001);
        for (int i = 8; i >= 1; i--) begin
            do_step(1'b0, 13'h0000, 1'b1, 1'b0);
            chk(pc, 16'(i * 256));
        end
        // return on an empty stack pops nothing and runs as a plain step
        do_step(1'b0, 13'h0000, 1'b1, 1'b0);
        chk(pc, 16'h0101);
        step_idle();
    endtask

    task automatic t_int();
        do_reset();
        for (int i = 1; i <= 8; i++) do_step(1'b1, 13'(i * 256), 1'b0, 1'b0);
        step_idle();
        int_req = 1'b1;
        @(negedge core_clk);
        int_req = 1'b0;
        chk(int_pending, 16'h0001);
        do_step(1'b0, 13'h0000, 1'b0, 1'b0);
        chk(int_ack, 16'h0000);
        do_step(1'b0, 13'h0000, 1'b1, 1'b0);
        do_step(1'b0, 13'h0000, 1'b0, 1'b0);
        chk(int_ack, 16'h0001);
        chk(pc, 16'h0040);
        // the return freed 0x700's level, so the interrupt saved 0x700
        do_step(1'b0, 13'h0000, 1'b0, 1'b1);
        chk(pc, 16'h0700);
        step_idle();
    endtask

    // every flavour; busy must last exactly two cycles before the write
    task automatic t_table();
        for (int f = 0; f < 4; f++) begin
            table_flavour = 2'(f);
            exp_w = f[0] ? 16'h3CC3 : 16'hA55A;
            table_req = 1'b1;
            @(negedge core_clk);
            table_req = 1'b0;
            chk(table_busy, 16'h0001);
            @(negedge core_clk);
            chk(table_busy, 16'h0001);
            @(negedge core_clk);
            chk({table_busy, dmem_we, table_done}, 16'h0003);
            chk(table_result_high_byte, {8'h00, exp_w[15:8]});
            @(negedge core_clk);
            chk(last_data, {8'h00, exp_w[7:0]});
            chk(last_wr, {5'h00, f[1] ? 3'h5 : 3'h0, 8'h21});
            chk(wr_count, 16'(f + 1));
        end
    endtask

    task automatic t_regs();
        int_req = 1'b1;
        @(negedge core_clk);
        int_req = 1'b0;
        int_clear = 1'b1;
        chk(int_pending, 16'h0001);
        @(negedge core_clk);
        int_clear = 1'b0;
        chk(int_pending, 16'h0000);
        table_result_high_byte_we = 1'b1;
        table_result_high_byte_wdata = 8'h5C;
        @(negedge core_clk);
        table_result_high_byte_we = 1'b0;
        chk(table_result_high_byte, 16'h005C);
        do_step(1'b1, 13'h1300, 1'b0, 1'b0);
        pcl_we = 1'b1;
        pcl_wdata = 8'h9A;
        do_step(1'b0, 13'h0000, 1'b0, 1'b0);
        pcl_we = 1'b0;
        step_idle();
        chk(pc, 16'h139A);
        chk(program_counter_low_byte, 16'h009A);
    endtask

    initial begin
        do_reset();
        t_reset();
        t_stack();
        t_int();
        t_table();
        t_regs();
        finish_test();
    end
endmodule
